//--- inc/hcs_pkg.sv
package hcs_pkg;

  // widths
  localparam int unsigned DW     = 32;
  localparam int unsigned AW     = 8;
  localparam int unsigned TW     = 16;
  localparam int unsigned LW     = 4;
  localparam int unsigned LSEL_W = 2;
  localparam int unsigned ST_W   = 6;
  localparam int unsigned IRQ_W  = 3;

  // register byte offsets
  localparam logic [AW-1:0] OFF_CMD   = 8'h00;
  localparam logic [AW-1:0] OFF_TARGET_SPEED_FIELD  = 8'h04;
  localparam logic [AW-1:0] OFF_TORQUE_LIMIT_FIELD  = 8'h08;
  localparam logic [AW-1:0] OFF_PRM   = 8'h0c;
  localparam logic [AW-1:0] OFF_APP1  = 8'h10;
  localparam logic [AW-1:0] OFF_APP1A = 8'h14;
  localparam logic [AW-1:0] OFF_APP2  = 8'h18;
  localparam logic [AW-1:0] OFF_APP2A = 8'h1c;
  localparam logic [AW-1:0] OFF_FINAL = 8'h20;
  localparam logic [AW-1:0] OFF_STAT  = 8'h24;
  localparam logic [AW-1:0] OFF_MON2  = 8'h28;
  localparam logic [AW-1:0] OFF_POS   = 8'h2c;
  localparam logic [AW-1:0] OFF_FEEDBACK_LATCH_POSITION  = 8'h30;
  localparam logic [AW-1:0] OFF_ISTAT = 8'h34;
  localparam logic [AW-1:0] OFF_IMASK = 8'h38;

  // field positions
  localparam int unsigned CMD_CODE_LSB  = 0;
  localparam int unsigned CMD_LSEL_LSB  = 8;
  localparam int unsigned PRM_DIR_BIT   = 0;
  localparam int unsigned PRM_ALT_BIT   = 1;
  localparam int unsigned STAT_LCMP_BIT = 0;
  localparam int unsigned STAT_BUSY_BIT = 1;
  localparam int unsigned STAT_FMON_BIT = 2;
  localparam int unsigned STAT_ST_LSB   = 8;
  localparam int unsigned IRQ_LATCH_BIT = 0;
  localparam int unsigned IRQ_DONE_BIT  = 1;
  localparam int unsigned IRQ_REJ_BIT   = 2;

  // codes and reset values
  localparam logic [7:0]    CMD_HOMING = 8'h3a;
  localparam logic [TW-1:0] TORQUE_LIMIT_FIELD_MAX   = 16'h4000;
  localparam logic [TW-1:0] TORQUE_LIMIT_FIELD_RST   = 16'h4000;
  localparam logic [DW-1:0] WORD_RST   = 32'h0;

  typedef enum logic [ST_W-1:0] {
    ST_IDLE  = 6'h01,
    ST_ACCEL = 6'h02,
    ST_APPR1 = 6'h04,
    ST_LATCH = 6'h08,
    ST_POSN  = 6'h10,
    ST_ZERO  = 6'h20
  } hcs_state_e;

  typedef struct packed {
    logic          psel;
    logic          penable;
    logic          pwrite;
    logic [AW-1:0] paddr;
    logic [DW-1:0] pwdata;
  } hcs_apb_req_s;

  typedef struct packed {
    logic [DW-1:0] prdata;
    logic          pready;
    logic          pslverr;
  } hcs_apb_rsp_s;

  typedef struct packed {
    logic [DW-1:0] speed;
    logic          dir;
    logic          pos_mode;
    logic [DW-1:0] target;
    logic [TW-1:0] torque_limit_field;
  } hcs_servo_s;

endpackage

//--- core/hcs_sync.sv
`timescale 1ns/100ps
module hcs_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta_ff;
  logic [W-1:0] sync_ff;

  // first stage is read by the second stage only
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= d_i;
      sync_ff <= meta_ff;
    end
  end

  assign q_o = sync_ff;

endmodule

//--- core/hcs_top.sv
`timescale 1ns/100ps
module hcs_top (
  input  wire logic                  clock_i,
  input  wire logic                  nrst_i,
  input  wire hcs_pkg::hcs_apb_req_s apb_i,
  input  wire logic                  comm_cycle_i,
  input  wire logic                  decel_switch_input_i,
  input  wire logic [3:0]            latch_in_i,
  input  wire logic [31:0]           axis_pos_i,
  input  wire logic                  pos_done_i,
  output hcs_pkg::hcs_apb_rsp_s      apb_o,
  output hcs_pkg::hcs_servo_s        servo_o,
  output logic                       coord_zero_o,
  output logic                       irq_o
);

  hcs_pkg::hcs_state_e   state_ff;
  hcs_pkg::hcs_apb_rsp_s rsp_ff;
  hcs_pkg::hcs_servo_s   servo_ff;
  logic [hcs_pkg::LW:0]      sync_w;
  logic [hcs_pkg::LW-1:0]    latch_w;
  logic                      dec_s;
  logic                      lat_cur;
  logic                      lat_prev_ff;
  logic                      lat_rise;
  logic [7:0]                resp_ff;
  logic [hcs_pkg::LSEL_W-1:0] lsel_ff;
  logic [31:0]               target_speed_field_ff;
  logic [15:0]               torque_limit_field_ff;
  logic                      dir_ff;
  logic                      alt_ff;
  logic [31:0]               app1_ff;
  logic [31:0]               app1a_ff;
  logic [31:0]               app2_ff;
  logic [31:0]               app2a_ff;
  logic [31:0]               final_ff;
  logic [31:0]               latch_pos_ff;
  logic [31:0]               tgt_ff;
  logic [31:0]               offset_ff;
  logic [31:0]               pos_rel;
  logic [31:0]               app1_sel;
  logic [31:0]               app2_sel;
  logic                      lcmp_ff;
  logic                      fmon_arm_ff;
  logic                      fmon_ff;
  logic                      czero_ff;
  logic                      irq_ff;
  logic [hcs_pkg::IRQ_W-1:0] istat_ff;
  logic [hcs_pkg::IRQ_W-1:0] imask_ff;
  logic [hcs_pkg::IRQ_W-1:0] ev;
  logic [hcs_pkg::IRQ_W-1:0] w1c;
  logic                      setup;
  logic                      wr;
  logic                      hit;
  logic                      wr_cmd;
  logic                      is_home;
  logic                      start;
  logic                      reject;
  logic                      latch_ev;
  logic [31:0]               rd_mux;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);

  // latch and decel switch pins cross into the clock domain before anything looks at them
  hcs_sync #(
    .W (hcs_pkg::LW + 1)
  ) u_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .d_i     ({latch_in_i, decel_switch_input_i}),
    .q_o     (sync_w)
  );

  assign dec_s    = sync_w[0];
  assign latch_w  = sync_w[hcs_pkg::LW:1];
  assign lat_cur  = latch_w[lsel_ff];
  // a latch level already high on entry is not an edge
  assign lat_rise = lat_cur & ~lat_prev_ff;
  assign latch_ev = (state_ff == hcs_pkg::ST_LATCH) & lat_rise;
  assign pos_rel  = axis_pos_i - offset_ff;
  assign app1_sel = alt_ff ? app1a_ff : app1_ff;
  assign app2_sel = alt_ff ? app2a_ff : app2_ff;

  // apb: no wait state, data captured in setup so prdata is a flop
  assign setup = apb_i.psel & ~apb_i.penable;
  assign wr = apb_i.psel & apb_i.penable & rsp_ff.pready & apb_i.pwrite
              & ~rsp_ff.pslverr;
  assign wr_cmd  = wr && (apb_i.paddr == hcs_pkg::OFF_CMD);
  assign is_home = apb_i.pwdata[hcs_pkg::CMD_CODE_LSB +: 8]
                   == hcs_pkg::CMD_HOMING;
  assign start  = wr_cmd & is_home & (state_ff == hcs_pkg::ST_IDLE);
  assign reject = wr_cmd & is_home & (state_ff != hcs_pkg::ST_IDLE);

  always_comb begin
    rd_mux = '0;
    hit    = 1'b1;
    case (apb_i.paddr)
      hcs_pkg::OFF_CMD: begin
        rd_mux[hcs_pkg::CMD_CODE_LSB +: 8] = resp_ff;
        rd_mux[hcs_pkg::CMD_LSEL_LSB +: hcs_pkg::LSEL_W] = lsel_ff;
      end
      hcs_pkg::OFF_TARGET_SPEED_FIELD:  rd_mux = target_speed_field_ff;
      hcs_pkg::OFF_TORQUE_LIMIT_FIELD:  rd_mux[15:0] = torque_limit_field_ff;
      hcs_pkg::OFF_PRM: begin
        rd_mux[hcs_pkg::PRM_DIR_BIT] = dir_ff;
        rd_mux[hcs_pkg::PRM_ALT_BIT] = alt_ff;
      end
      hcs_pkg::OFF_APP1:  rd_mux = app1_ff;
      hcs_pkg::OFF_APP1A: rd_mux = app1a_ff;
      hcs_pkg::OFF_APP2:  rd_mux = app2_ff;
      hcs_pkg::OFF_APP2A: rd_mux = app2a_ff;
      hcs_pkg::OFF_FINAL: rd_mux = final_ff;
      hcs_pkg::OFF_STAT: begin
        rd_mux[hcs_pkg::STAT_LCMP_BIT] = lcmp_ff;
        rd_mux[hcs_pkg::STAT_BUSY_BIT] = state_ff != hcs_pkg::ST_IDLE;
        rd_mux[hcs_pkg::STAT_FMON_BIT] = fmon_ff;
        rd_mux[hcs_pkg::STAT_ST_LSB +: hcs_pkg::ST_W] = state_ff;
      end
      hcs_pkg::OFF_MON2:  rd_mux = fmon_ff ? latch_pos_ff : pos_rel;
      hcs_pkg::OFF_POS:   rd_mux = pos_rel;
      hcs_pkg::OFF_FEEDBACK_LATCH_POSITION:  rd_mux = latch_pos_ff;
      hcs_pkg::OFF_ISTAT: rd_mux[hcs_pkg::IRQ_W-1:0] = istat_ff;
      hcs_pkg::OFF_IMASK: rd_mux[hcs_pkg::IRQ_W-1:0] = imask_ff;
      default:            hit = 1'b0;
    endcase
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsp_ff <= '0;
    end else begin
      rsp_ff.pready <= setup;
      if (setup) begin
        rsp_ff.prdata  <= rd_mux;
        rsp_ff.pslverr <= ~hit;
      end
    end
  end

  // configuration registers
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      target_speed_field_ff  <= hcs_pkg::WORD_RST;
      torque_limit_field_ff  <= hcs_pkg::TORQUE_LIMIT_FIELD_RST;
      dir_ff   <= 1'b0;
      alt_ff   <= 1'b0;
      app1_ff  <= hcs_pkg::WORD_RST;
      app1a_ff <= hcs_pkg::WORD_RST;
      app2_ff  <= hcs_pkg::WORD_RST;
      app2a_ff <= hcs_pkg::WORD_RST;
      final_ff <= hcs_pkg::WORD_RST;
      imask_ff <= '0;
    end else if (wr) begin
      case (apb_i.paddr)
        hcs_pkg::OFF_TARGET_SPEED_FIELD:  target_speed_field_ff  <= apb_i.pwdata;
        hcs_pkg::OFF_TORQUE_LIMIT_FIELD:  torque_limit_field_ff  <= apb_i.pwdata[15:0];
        hcs_pkg::OFF_PRM: begin
          dir_ff <= apb_i.pwdata[hcs_pkg::PRM_DIR_BIT];
          alt_ff <= apb_i.pwdata[hcs_pkg::PRM_ALT_BIT];
        end
        hcs_pkg::OFF_APP1:  app1_ff  <= apb_i.pwdata;
        hcs_pkg::OFF_APP1A: app1a_ff <= apb_i.pwdata;
        hcs_pkg::OFF_APP2:  app2_ff  <= apb_i.pwdata;
        hcs_pkg::OFF_APP2A: app2a_ff <= apb_i.pwdata;
        hcs_pkg::OFF_FINAL: final_ff <= apb_i.pwdata;
        hcs_pkg::OFF_IMASK: imask_ff <= apb_i.pwdata[hcs_pkg::IRQ_W-1:0];
        default: ;
      endcase
    end
  end

  // command byte echo; latch select only moves when homing starts
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      resp_ff <= 8'h00;
      lsel_ff <= '0;
    end else begin
      if (wr_cmd) begin
        resp_ff <= apb_i.pwdata[hcs_pkg::CMD_CODE_LSB +: 8];
      end
      if (start) begin
        lsel_ff <= apb_i.pwdata[hcs_pkg::CMD_LSEL_LSB +: hcs_pkg::LSEL_W];
      end
    end
  end

  property p_echo;
    wr_cmd |=> resp_ff == $past(apb_i.pwdata[7:0]);
  endproperty
  a_echo: assert property (p_echo)
    else $error("response byte differs from command byte");

  // homing sequencer
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_ff <= hcs_pkg::ST_IDLE;
    end else begin
      case (state_ff)
        hcs_pkg::ST_IDLE:  if (start) state_ff <= hcs_pkg::ST_ACCEL;
        hcs_pkg::ST_ACCEL: if (dec_s) state_ff <= hcs_pkg::ST_APPR1;
        hcs_pkg::ST_APPR1: if (!dec_s) state_ff <= hcs_pkg::ST_LATCH;
        hcs_pkg::ST_LATCH: if (lat_rise) state_ff <= hcs_pkg::ST_POSN;
        hcs_pkg::ST_POSN: begin
          if (pos_done_i) begin
            state_ff <= hcs_pkg::ST_ZERO;
          end
        end
        hcs_pkg::ST_ZERO:  state_ff <= hcs_pkg::ST_IDLE;
        default:           state_ff <= hcs_pkg::ST_IDLE;
      endcase
    end
  end

  property p_order;
    $changed(state_ff) |->
      ($past(state_ff) == hcs_pkg::ST_IDLE  && state_ff == hcs_pkg::ST_ACCEL)
   || ($past(state_ff) == hcs_pkg::ST_ACCEL && state_ff == hcs_pkg::ST_APPR1)
   || ($past(state_ff) == hcs_pkg::ST_APPR1 && state_ff == hcs_pkg::ST_LATCH)
   || ($past(state_ff) == hcs_pkg::ST_LATCH && state_ff == hcs_pkg::ST_POSN)
   || ($past(state_ff) == hcs_pkg::ST_POSN  && state_ff == hcs_pkg::ST_ZERO)
   || ($past(state_ff) == hcs_pkg::ST_ZERO  && state_ff == hcs_pkg::ST_IDLE);
  endproperty
  a_order: assert property (p_order)
    else $error("homing step skipped or reordered");

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lat_prev_ff <= 1'b0;
    end else begin
      lat_prev_ff <= lat_cur;
    end
  end

  // latch capture; position stays in machine coordinates
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      latch_pos_ff <= hcs_pkg::WORD_RST;
      tgt_ff       <= hcs_pkg::WORD_RST;
    end else if (latch_ev) begin
      latch_pos_ff <= axis_pos_i;
      tgt_ff       <= axis_pos_i + final_ff;
    end
  end

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lcmp_ff <= 1'b0;
    end else if (latch_ev) begin
      lcmp_ff <= 1'b1;
    end else if (state_ff == hcs_pkg::ST_ZERO) begin
      lcmp_ff <= 1'b0;
    end
  end

  // monitor two override waits for the next cycle boundary, then holds
  // for exactly one communications cycle
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fmon_arm_ff <= 1'b0;
      fmon_ff     <= 1'b0;
    end else begin
      if (latch_ev) begin
        fmon_arm_ff <= 1'b1;
      end else if (comm_cycle_i) begin
        fmon_arm_ff <= 1'b0;
      end
      if (comm_cycle_i) begin
        fmon_ff <= fmon_arm_ff & ~latch_ev;
      end
    end
  end

  property p_fmon;
    fmon_ff && comm_cycle_i |=> !fmon_ff;
  endproperty
  a_fmon: assert property (p_fmon)
    else $error("monitor override held past one cycle");

  // coordinate reset: the reached spot becomes the new origin
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      offset_ff <= hcs_pkg::WORD_RST;
      czero_ff  <= 1'b0;
    end else begin
      czero_ff <= state_ff == hcs_pkg::ST_ZERO;
      if (state_ff == hcs_pkg::ST_ZERO) begin
        offset_ff <= axis_pos_i;
      end
    end
  end

  property p_zero;
    state_ff == hcs_pkg::ST_ZERO |=>
      offset_ff == $past(axis_pos_i) && czero_ff && !lcmp_ff;
  endproperty
  a_zero: assert property (p_zero)
    else $error("coordinates not zeroed at homing end");

  // servo command, registered from the state
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      servo_ff <= '0;
      servo_ff.torque_limit_field <= hcs_pkg::TORQUE_LIMIT_FIELD_RST;
    end else begin
      case (state_ff)
        hcs_pkg::ST_ACCEL: servo_ff.speed <= target_speed_field_ff;
        hcs_pkg::ST_APPR1: servo_ff.speed <= app1_sel;
        hcs_pkg::ST_LATCH: servo_ff.speed <= app1_sel;
        hcs_pkg::ST_POSN:  servo_ff.speed <= app2_sel;
        default:           servo_ff.speed <= '0;
      endcase
      servo_ff.dir      <= dir_ff;
      servo_ff.pos_mode <= state_ff == hcs_pkg::ST_POSN;
      servo_ff.target   <= tgt_ff;
      // clamp rather than wrap, so a bad code cannot reduce the limit
      servo_ff.torque_limit_field <= (torque_limit_field_ff > hcs_pkg::TORQUE_LIMIT_FIELD_MAX) ?
                       hcs_pkg::TORQUE_LIMIT_FIELD_MAX : torque_limit_field_ff;
    end
  end

  property p_start;
    start |=> state_ff == hcs_pkg::ST_ACCEL;
  endproperty
  a_start: assert property (p_start)
    else $error("homing command not accepted");

  property p_accel;
    state_ff == hcs_pkg::ST_ACCEL |=>
      servo_ff.speed == $past(target_speed_field_ff) && servo_ff.dir == $past(dir_ff);
  endproperty
  a_accel: assert property (p_accel)
    else $error("accel speed does not follow target speed");

  sequence s_dec_hit;
    state_ff == hcs_pkg::ST_ACCEL && dec_s;
  endsequence
  property p_dec_hit;
    s_dec_hit |=> (state_ff == hcs_pkg::ST_APPR1)
      ##1 (servo_ff.speed == $past(app1_sel));
  endproperty
  a_dec_hit: assert property (p_dec_hit)
    else $error("no slow down to approach speed one");

  sequence s_dec_rel;
    state_ff == hcs_pkg::ST_APPR1 && !dec_s;
  endsequence
  property p_dec_rel;
    s_dec_rel |=> state_ff == hcs_pkg::ST_LATCH;
  endproperty
  a_dec_rel: assert property (p_dec_rel)
    else $error("latch wait not started on switch release");

  sequence s_latch;
    latch_ev;
  endsequence
  property p_latch;
    s_latch |=> (state_ff == hcs_pkg::ST_POSN && lcmp_ff
      && latch_pos_ff == $past(axis_pos_i)
      && tgt_ff == $past(axis_pos_i) + $past(final_ff))
      ##1 (servo_ff.pos_mode && servo_ff.target == $past(tgt_ff)
      && servo_ff.speed == $past(app2_sel));
  endproperty
  a_latch: assert property (p_latch)
    else $error("latch did not start final positioning");

  // pass-through below full scale, pinned at full scale above it
  property p_torque_limit_field;
    1'b1 |=> (($past(torque_limit_field_ff) > hcs_pkg::TORQUE_LIMIT_FIELD_MAX) ?
      servo_ff.torque_limit_field == hcs_pkg::TORQUE_LIMIT_FIELD_MAX : servo_ff.torque_limit_field == $past(torque_limit_field_ff));
  endproperty
  a_torque_limit_field: assert property (p_torque_limit_field)
    else $error("torque limit above full scale");

  // interrupts: a new event beats a same-cycle clear
  assign ev[hcs_pkg::IRQ_LATCH_BIT] = latch_ev;
  assign ev[hcs_pkg::IRQ_DONE_BIT]  = state_ff == hcs_pkg::ST_ZERO;
  assign ev[hcs_pkg::IRQ_REJ_BIT]   = reject;
  assign w1c = (wr && apb_i.paddr == hcs_pkg::OFF_ISTAT) ?
               apb_i.pwdata[hcs_pkg::IRQ_W-1:0] : '0;

  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      istat_ff <= '0;
      irq_ff   <= 1'b0;
    end else begin
      istat_ff <= (istat_ff & ~w1c) | ev;
      irq_ff   <= |(istat_ff & imask_ff);
    end
  end

  assign apb_o        = rsp_ff;
  assign servo_o      = servo_ff;
  assign coord_zero_o = czero_ff;
  assign irq_o        = irq_ff;

endmodule

//--- tb/hcs_servo_model.sv
`timescale 1ns/100ps
module hcs_servo_model (
  input  wire logic                clock_i,
  input  wire logic                nrst_i,
  input  wire hcs_pkg::hcs_servo_s servo_i,
  input  wire logic                hold_i,
  output logic              [31:0] axis_pos_o,
  output logic                     pos_done_o
);
  // starts far from zero so no walk ever wraps round
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      axis_pos_o <= 32'h0000_1000;
    end else if (hold_i) begin
      axis_pos_o <= axis_pos_o;
    end else if (servo_i.pos_mode) begin
      if (axis_pos_o < servo_i.target) begin
        axis_pos_o <= axis_pos_o + 32'h1;
      end else if (axis_pos_o > servo_i.target) begin
        axis_pos_o <= axis_pos_o - 32'h1;
      end
    end else if (servo_i.speed != 32'h0) begin
      axis_pos_o <= servo_i.dir ? axis_pos_o - 32'h1 : axis_pos_o + 32'h1;
    end
  end
  // stops on target so the homed spot reads exactly zero
  assign pos_done_o = servo_i.pos_mode && (axis_pos_o == servo_i.target);
endmodule

//--- tb/hcs_top_bench.sv
`timescale 1ns/100ps
module hcs_top_bench;
  logic                  clock_i;
  logic                  nrst_i;
  hcs_pkg::hcs_apb_req_s req;
  hcs_pkg::hcs_apb_rsp_s rsp;
  hcs_pkg::hcs_servo_s   srv;
  logic                  comm;
  logic                  decel;
  logic            [3:0] latch;
  logic           [31:0] axis;
  logic                  done;
  logic                  hold;
  logic                  czero;
  logic                  irq;
  int                    err_count;
  int                    tests_run;
  logic           [31:0] rd_d;
  logic                  rd_e;

  hcs_top i_hcs_top (
    .clock_i(clock_i), .nrst_i(nrst_i), .apb_i(req), .comm_cycle_i(comm),
    .decel_switch_input_i(decel), .latch_in_i(latch), .axis_pos_i(axis),
    .pos_done_i(done), .apb_o(rsp), .servo_o(srv), .coord_zero_o(czero),
    .irq_o(irq)
  );
  hcs_servo_model i_hcs_servo_model (
    .clock_i(clock_i), .nrst_i(nrst_i), .servo_i(srv), .hold_i(hold),
    .axis_pos_o(axis), .pos_done_o(done)
  );

  initial begin
    clock_i = 1'b0;
    forever #2 clock_i = ~clock_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  function automatic logic [15:0] clamp(input logic [15:0] t);
    return (t > hcs_pkg::TORQUE_LIMIT_FIELD_MAX) ? hcs_pkg::TORQUE_LIMIT_FIELD_MAX : t;
  endfunction

  // two idle cycles after each transfer: registered outputs fed by the
  // written register have settled by the time the caller looks
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    n = 0;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge clock_i);
    req.penable <= 1'b1;
    do begin
      @(posedge clock_i);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd_d = rsp.prdata;
    rd_e = rsp.pslverr;
    req <= '0;
    if (n >= 50) chk("pready", 32'h0, 32'h1);
    repeat (2) @(posedge clock_i);
  endtask

  task automatic wait_st(input logic [5:0] st);
    int n;
    n = 0;
    do begin
      apb(1'b0, hcs_pkg::OFF_STAT, 32'h0);
      n++;
    end while (rd_d[13:8] !== st && n < 100);
    chk("state", 32'(rd_d[13:8]), 32'(st));
  endtask

  task automatic pulse(input logic [1:0] ch);
    latch[ch] <= 1'b1;
    repeat (4) @(posedge clock_i);
    latch[ch] <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  task automatic commp();
    comm <= 1'b1;
    @(posedge clock_i);
    comm <= 1'b0;
  endtask

  initial begin
    repeat (40000) @(posedge clock_i);
    err_count++;
    complete_run();
  end

  initial begin
    logic [31:0] target_speed_field, a1, a1a, a2, a2a, fin, p, v;
    logic [15:0] tl [5];
    logic [1:0]  ls;
    logic        dr;
    int          n;
    err_count = 0;
    tests_run = 0;
    req = '0;
    comm = 1'b0;
    decel = 1'b0;
    latch = 4'h0;
    hold = 1'b0;
    nrst_i = 1'b0;
    v = $urandom(32'h60b5);
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    chk("torque_limit_field out", 32'(srv.torque_limit_field), 32'(hcs_pkg::TORQUE_LIMIT_FIELD_RST));
    apb(1'b0, hcs_pkg::OFF_TORQUE_LIMIT_FIELD, 32'h0);
    chk("torque_limit_field reg", rd_d, 32'(hcs_pkg::TORQUE_LIMIT_FIELD_RST));
    apb(1'b0, hcs_pkg::OFF_STAT, 32'h0);
    chk("stat", rd_d, {18'h0, hcs_pkg::ST_IDLE, 8'h0});
    tl = '{16'h4000, 16'h4001, 16'hffff, 16'h3fff, 16'($urandom)};
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, hcs_pkg::OFF_TORQUE_LIMIT_FIELD, 32'(tl[i]));
      chk("torque_limit_field out", 32'(srv.torque_limit_field), 32'(clamp(tl[i])));
    end
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped err", 32'(rd_e), 32'h1);
    chk("unmapped data", rd_d, 32'h0);
    apb(1'b1, hcs_pkg::OFF_CMD, 32'h0000_0355);
    apb(1'b0, hcs_pkg::OFF_CMD, 32'h0);
    chk("echo other", 32'(rd_d[9:0]), 32'h0000_0055);
    apb(1'b0, hcs_pkg::OFF_STAT, 32'h0);
    chk("other code", 32'(rd_d[13:8]), 32'(hcs_pkg::ST_IDLE));
    for (int k = 0; k < 2; k++) begin
      dr = 1'($urandom);
      ls = 2'($urandom);
      target_speed_field = $urandom | 32'h1;
      a1 = $urandom | 32'h1;
      a1a = $urandom | 32'h1;
      a2 = $urandom | 32'h1;
      a2a = $urandom | 32'h1;
      fin = 32'(1 + $urandom % 30);
      apb(1'b1, hcs_pkg::OFF_PRM, {30'h0, k[0], dr});
      apb(1'b1, hcs_pkg::OFF_TARGET_SPEED_FIELD, target_speed_field);
      apb(1'b1, hcs_pkg::OFF_APP1, a1);
      apb(1'b1, hcs_pkg::OFF_APP1A, a1a);
      apb(1'b1, hcs_pkg::OFF_APP2, a2);
      apb(1'b1, hcs_pkg::OFF_APP2A, a2a);
      apb(1'b1, hcs_pkg::OFF_FINAL, fin);
      apb(1'b1, hcs_pkg::OFF_CMD, {22'h0, ls, hcs_pkg::CMD_HOMING});
      apb(1'b0, hcs_pkg::OFF_CMD, 32'h0);
      chk("echo", 32'(rd_d[9:0]), {22'h0, ls, hcs_pkg::CMD_HOMING});
      wait_st(hcs_pkg::ST_ACCEL);
      chk("speed", srv.speed, target_speed_field);
      chk("dir", 32'(srv.dir), 32'(dr));
      pulse(ls);
      wait_st(hcs_pkg::ST_ACCEL);
      target_speed_field = $urandom | 32'h1;
      apb(1'b1, hcs_pkg::OFF_TARGET_SPEED_FIELD, target_speed_field);
      chk("speed", srv.speed, target_speed_field);
      decel <= 1'b1;
      wait_st(hcs_pkg::ST_APPR1);
      chk("speed", srv.speed, k ? a1a : a1);
      apb(1'b1, hcs_pkg::OFF_TARGET_SPEED_FIELD, ~target_speed_field);
      chk("speed", srv.speed, k ? a1a : a1);
      // latch level already high on entry must not count as an edge
      latch[ls] <= 1'b1;
      decel <= 1'b0;
      wait_st(hcs_pkg::ST_LATCH);
      repeat (6) @(posedge clock_i);
      wait_st(hcs_pkg::ST_LATCH);
      latch[ls] <= 1'b0;
      repeat (4) @(posedge clock_i);
      pulse(ls + 2'd1);
      wait_st(hcs_pkg::ST_LATCH);
      // frozen axis keeps the positioning window open for sampling
      hold <= 1'b1;
      repeat (2) @(posedge clock_i);
      p = axis;
      pulse(ls);
      wait_st(hcs_pkg::ST_POSN);
      chk("pos_mode", 32'(srv.pos_mode), 32'h1);
      chk("target", srv.target, p + fin);
      chk("speed", srv.speed, k ? a2a : a2);
      apb(1'b0, hcs_pkg::OFF_FEEDBACK_LATCH_POSITION, 32'h0);
      chk("feedback_latch_position", rd_d, p);
      apb(1'b0, hcs_pkg::OFF_STAT, 32'h0);
      chk("lcmp", 32'(rd_d[0]), 32'h1);
      commp();
      apb(1'b0, hcs_pkg::OFF_STAT, 32'h0);
      chk("mon force", 32'(rd_d[2]), 32'h1);
      apb(1'b0, hcs_pkg::OFF_MON2, 32'h0);
      chk("mon2", rd_d, p);
      commp();
      apb(1'b0, hcs_pkg::OFF_STAT, 32'h0);
      chk("mon force", 32'(rd_d[2]), 32'h0);
      apb(1'b1, hcs_pkg::OFF_CMD, {22'h0, ls, hcs_pkg::CMD_HOMING});
      wait_st(hcs_pkg::ST_POSN);
      apb(1'b0, hcs_pkg::OFF_ISTAT, 32'h0);
      chk("istat", 32'(rd_d[2:0]), 32'h5);
      chk("irq masked", 32'(irq), 32'h0);
      apb(1'b1, hcs_pkg::OFF_IMASK, 32'h4);
      chk("irq", 32'(irq), 32'h1);
      apb(1'b1, hcs_pkg::OFF_ISTAT, 32'h4);
      chk("irq clear", 32'(irq), 32'h0);
      hold <= 1'b0;
      n = 0;
      while (czero !== 1'b1 && n < 2000) begin
        @(posedge clock_i);
        n++;
      end
      chk("coord zero", 32'(czero), 32'h1);
      apb(1'b0, hcs_pkg::OFF_POS, 32'h0);
      chk("pos", rd_d, 32'h0);
      apb(1'b0, hcs_pkg::OFF_MON2, 32'h0);
      chk("mon2 pos", rd_d, 32'h0);
      apb(1'b0, hcs_pkg::OFF_STAT, 32'h0);
      chk("stat", 32'(rd_d[13:0]), {18'h0, hcs_pkg::ST_IDLE, 8'h0});
      apb(1'b0, hcs_pkg::OFF_ISTAT, 32'h0);
      chk("done irq", 32'(rd_d[1]), 32'h1);
      apb(1'b1, hcs_pkg::OFF_ISTAT, 32'h7);
      apb(1'b1, hcs_pkg::OFF_IMASK, 32'h0);
    end
    complete_run();
  end
endmodule
